// File: core/t1_receive_alarm_monitor.sv
// t1 receive alarm monitor: los, blue and yellow alarm supervision,
// zero and pulse-density checks, transmit short and ones-density checks.
// assumes rx/tx bit strobes come from framer logic on pclk; only the
// analog current-limit pin is asynchronous.
// Function
// - blue alarm onset and recovery shown live and as an event bit
// - blue alarm sent to line only while send_blue_alarm is set
// - loss of signal onset and recovery shown live and as event
// - yellow alarm live flag, separate detect and release events
// - yellow alarm sent only while send_yellow_alarm is set
// - latch zero excess: over 7 zeros b8zs, over 15 ami; read clears
// - density violation shown as status flag and first event register
// - latch density: under N ones in 8(N+1) bits, or over 15 zeros
// - transmit short detect and release flagged, line change event
// - transmit ones-density failure flagged, shares line change event
// - loss of signal after programmed 16 to 4096 zero periods
// - loss cleared by programmed 1 to 256 ones within interval
// - loss also cleared by density met, no run over 15 zeros
// - selector 0: blue when under 3 zeros in 12 or 24 frames
// - selector 1: blue when under 4 in 12, under 6 in 24 frames
// - blue held one multiframe; cleared above 2, or 3/5 zeros
// - selector 0 yellow: bit 2 zero 255 slots, fs12 one, dl pattern
// - selector 1 yellow: bit 2 zero in every slot of a frame
// - release: conditions gone, or absent three frames/multiframes/dl
// - selector 1 yellow detection tolerant of a 1e-3 bit error rate
// - transmit short after over 3 periods of high current, clear off
// - transmit ones failure after 32 zeros, cleared by any pulse
`timescale 1ns/100ps
module t1_receive_alarm_monitor
  import alarm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_bit,
  input wire logic rx_frame_start,
  input wire logic rx_slot_start,
  input wire logic rx_fs12,
  input wire logic rx_dl,
  input wire logic tx_valid,
  input wire logic tx_bit,
  input wire logic tx_current_high,
  output logic tx_blue_alarm,
  output logic tx_yellow_alarm
);

  typedef struct packed {
    logic [ctrl_width-1:0] ctrl;
    logic [los_cfg_width-1:0] los_cfg;
    logic blue;
    logic signal_loss_status;
    logic yellow;
    logic exz;
    logic density_violation;
    logic tx_short;
    logic tx_zero;
    logic irq_status_0;
    logic irq_status_1;
    logic [3:0] irq_status_2;
    logic [12:0] zrun;
    logic [7:0] seen;
    logic [density_n_max-1:0][7:0] age;
    logic [12:0] lwin;
    logic [8:0] lones;
    logic lbad;
    logic [4:0] bframe;
    logic [7:0] bzeros;
    logic [2:0] bitpos;
    logic [7:0] b2run;
    logic fr_allz;
    logic [1:0] fr_miss;
    logic ya;
    logic [1:0] fs_miss;
    logic yb;
    logic [15:0] dl_sh;
    logic [5:0] dl_miss;
    logic yc;
    logic [1:0] lim_sync;
    logic [1:0] lim_cnt;
    logic [5:0] tzrun;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  // sliding-window density check: age of the k-th most recent one
  logic [density_n_max-1:0][7:0] age_upd;
  logic [density_n_max-1:0] win_viol;
  logic [7:0] seen_upd;

  assign seen_upd = (s_r.seen == 8'hff) ? s_r.seen : s_r.seen + 8'h01;

  genvar gi;
  generate
    for (gi = 0; gi < density_n_max; gi++)
    begin : g_age
      logic [7:0] older;
      logic [7:0] win_len;
      if (gi == 0)
      begin : g_first
        assign older = 8'hff;
      end
      else
      begin : g_rest
        assign older = s_r.age[gi-1];
      end
      assign win_len = 8'(8 * (gi + 2));
      always_comb
      begin
        if (rx_bit && gi == 0)
          age_upd[gi] = 8'h00;
        else if (rx_bit)
          age_upd[gi] = (older == 8'hff) ? older : older + 8'h01;
        else
          age_upd[gi] = (s_r.age[gi] == 8'hff) ? s_r.age[gi] :
                        s_r.age[gi] + 8'h01;
      end
      // fewer than N ones in the window means the N-th one is too old
      assign win_viol[gi] = (age_upd[gi] >= win_len) &&
                            (seen_upd >= win_len);
    end
  endgenerate

  logic lim;
  logic [11:0] int_m1;
  logic [8:0] ones_m1;
  logic esf;
  logic [4:0] nframes;
  logic [7:0] blue_set;
  logic [7:0] blue_clr;
  logic pdv_now;
  logic [12:0] zrun_upd;
  logic [2:0] pos;
  logic dl_match;
  logic apb_done;
  logic blue_new;
  logic los_new;
  logic yellow_new;
  logic short_new;
  logic tzero_new;
  logic exz_now;
  logic [3:0] irq_status_2_ev;

  always_comb
  begin
    s_nxt = s_r;
    lim = s_r.lim_sync[1];
    esf = s_r.ctrl[esf_mode_bit];
    int_m1 = s_r.los_cfg[los_int_lsb +: 12];
    if (int_m1 < los_int_min_m1)
      int_m1 = los_int_min_m1;
    ones_m1 = {1'b0, s_r.los_cfg[los_ones_lsb +: 8]};
    nframes = esf ? frames_esf : frames_d4;
    if (s_r.ctrl[blue_threshold_sel_bit])
    begin
      blue_set = esf ? blue_set_1_esf : blue_set_1_d4;
      blue_clr = esf ? blue_clr_1_esf : blue_clr_1_d4;
    end
    else
    begin
      blue_set = blue_set_0;
      blue_clr = blue_clr_0;
    end
    zrun_upd = rx_bit ? 13'h0000 :
               (&s_r.zrun ? s_r.zrun : s_r.zrun + 13'h0001);
    pdv_now = (|win_viol) || (zrun_upd > zero_run_max);
    exz_now = zrun_upd > (s_r.ctrl[b8zs_mode_bit] ? exz_b8zs_max :
                          exz_ami_max);
    pos = rx_slot_start ? 3'd1 : s_r.bitpos + 3'd1;
    dl_match = ({s_r.dl_sh[14:0], rx_bit} == dl_yellow_pattern);
    blue_new = s_r.blue;
    los_new = s_r.signal_loss_status;
    short_new = s_r.tx_short;
    tzero_new = s_r.tx_zero;
    irq_status_2_ev = 4'h0;

    // metastability guard on the analog comparator pin
    s_nxt.lim_sync = {s_r.lim_sync[0], tx_current_high};

    if (rx_valid)
    begin
      s_nxt.zrun = zrun_upd;
      s_nxt.seen = seen_upd;
      s_nxt.age = age_upd;
      if (exz_now)
        s_nxt.exz = 1'b1;
      if (pdv_now)
      begin
        s_nxt.density_violation = 1'b1;
        s_nxt.irq_status_0 = 1'b1;
      end

      // loss of signal and its recovery interval
      if (!s_r.signal_loss_status)
      begin
        if (zrun_upd > {1'b0, int_m1})
          los_new = 1'b1;
      end
      else
      begin
        s_nxt.lwin = s_r.lwin + 13'h0001;
        s_nxt.lones = (&s_r.lones) ? s_r.lones :
                      s_r.lones + {8'h00, rx_bit};
        s_nxt.lbad = s_r.lbad || pdv_now;
        if (s_nxt.lones > ones_m1)
          los_new = 1'b0;
        else if (s_r.lwin == {1'b0, int_m1})
        begin
          if (s_r.los_cfg[los_dens_bit] && !s_nxt.lbad)
            los_new = 1'b0;
          s_nxt.lwin = 13'h0000;
          s_nxt.lones = 9'h000;
          s_nxt.lbad = 1'b0;
        end
      end

      // blue alarm: zeros counted over one multiframe of frames
      if (rx_frame_start)
      begin
        if (s_r.bframe == nframes - 5'd1)
        begin
          if (!s_r.blue && s_r.bzeros < blue_set)
            blue_new = 1'b1;
          // a window always spans one multiframe, so the alarm holds
          // at least that long before it can clear
          else if (s_r.blue && s_r.bzeros > blue_clr)
            blue_new = 1'b0;
          s_nxt.bframe = 5'd0;
          s_nxt.bzeros = {7'h00, ~rx_bit};
        end
        else
        begin
          s_nxt.bframe = s_r.bframe + 5'd1;
          s_nxt.bzeros = s_r.bzeros + {7'h00, ~rx_bit & ~&s_r.bzeros};
        end
        // per-frame bit 2 check for selector 1
        if (s_r.fr_allz)
        begin
          s_nxt.ya = s_r.ctrl[yellow_detect_sel_bit] ? 1'b1 : s_r.ya;
          s_nxt.fr_miss = 2'd0;
        end
        else if (s_r.ctrl[yellow_detect_sel_bit])
        begin
          s_nxt.fr_miss = (s_r.fr_miss == yellow_rel_count) ?
                          s_r.fr_miss : s_r.fr_miss + 2'd1;
          if (s_nxt.fr_miss == yellow_rel_count)
            s_nxt.ya = 1'b0;
        end
        s_nxt.fr_allz = 1'b1;
      end
      else
      begin
        s_nxt.bzeros = s_r.bzeros + {7'h00, ~rx_bit & ~&s_r.bzeros};
        s_nxt.bitpos = pos;
        if (pos == 3'd2)
        begin
          if (rx_bit)
          begin
            s_nxt.fr_allz = 1'b0;
            s_nxt.b2run = 8'h00;
            if (!s_r.ctrl[yellow_detect_sel_bit])
              s_nxt.ya = 1'b0;
          end
          else
          begin
            s_nxt.b2run = (s_r.b2run == yellow_slots) ? s_r.b2run :
                          s_r.b2run + 8'h01;
            if (!s_r.ctrl[yellow_detect_sel_bit] &&
                s_nxt.b2run == yellow_slots)
              s_nxt.ya = 1'b1;
          end
        end
      end

      // d4: fs bit of frame 12 set by the far end
      if (rx_fs12 && !esf)
      begin
        if (rx_bit)
        begin
          s_nxt.yb = 1'b1;
          s_nxt.fs_miss = 2'd0;
        end
        else
        begin
          s_nxt.fs_miss = (s_r.fs_miss == yellow_rel_count) ?
                          s_r.fs_miss : s_r.fs_miss + 2'd1;
          if (!s_r.ctrl[yellow_detect_sel_bit] ||
              s_nxt.fs_miss == yellow_rel_count)
            s_nxt.yb = 1'b0;
        end
      end

      // esf: eight ones then eight zeros on the data link
      if (rx_dl && esf)
      begin
        s_nxt.dl_sh = {s_r.dl_sh[14:0], rx_bit};
        if (dl_match)
        begin
          s_nxt.yc = 1'b1;
          s_nxt.dl_miss = 6'd0;
        end
        else
        begin
          s_nxt.dl_miss = (&s_r.dl_miss) ? s_r.dl_miss :
                          s_r.dl_miss + 6'd1;
          // tolerating single errored patterns keeps the alarm steady
          // under line errors in the slower release mode
          if (s_nxt.dl_miss == (s_r.ctrl[yellow_detect_sel_bit] ?
              6'(dl_len * yellow_rel_count) : dl_len))
            s_nxt.yc = 1'b0;
        end
      end
    end
    if (!esf)
      s_nxt.yc = 1'b0;
    else
      s_nxt.yb = 1'b0;
    yellow_new = s_nxt.ya || s_nxt.yb || s_nxt.yc;

    // restart evaluation intervals on every loss or blue alarm change
    if (los_new != s_r.signal_loss_status)
    begin
      s_nxt.lwin = 13'h0000;
      s_nxt.lones = 9'h000;
      s_nxt.lbad = 1'b0;
      irq_status_2_ev[los_bit] = 1'b1;
    end
    if (blue_new != s_r.blue)
    begin
      s_nxt.bframe = 5'd0;
      irq_status_2_ev[blue_bit] = 1'b1;
    end
    if (yellow_new && !s_r.yellow)
      irq_status_2_ev[yellow_bit] = 1'b1;
    if (!yellow_new && s_r.yellow)
      irq_status_2_ev[yellow_rel_bit] = 1'b1;
    s_nxt.irq_status_2 = s_r.irq_status_2 | irq_status_2_ev;

    // transmit line supervision
    if (!lim)
    begin
      s_nxt.lim_cnt = 2'd0;
      short_new = 1'b0;
    end
    else if (tx_valid)
    begin
      if (s_r.lim_cnt == tx_short_periods)
        short_new = 1'b1;
      else
        s_nxt.lim_cnt = s_r.lim_cnt + 2'd1;
    end
    if (tx_valid)
    begin
      if (tx_bit)
      begin
        s_nxt.tzrun = 6'd0;
        tzero_new = 1'b0;
      end
      else
      begin
        s_nxt.tzrun = (s_r.tzrun == tx_zero_limit) ? s_r.tzrun :
                      s_r.tzrun + 6'd1;
        if (s_nxt.tzrun == tx_zero_limit)
          tzero_new = 1'b1;
      end
    end
    if (short_new != s_r.tx_short || tzero_new != s_r.tx_zero)
      s_nxt.irq_status_1 = 1'b1;

    // apb slave: two-cycle access phase, read data captured with pready
    apb_done = psel && penable && s_r.ready;
    s_nxt.ready = psel && penable && !s_r.ready;
    if (psel && penable && !s_r.ready)
    begin
      s_nxt.slverr = 1'b0;
      s_nxt.rdata = 32'h00000000;
      if (paddr == ctrl_addr)
        s_nxt.rdata[ctrl_width-1:0] = s_r.ctrl;
      else if (paddr == los_cfg_addr)
        s_nxt.rdata[los_cfg_width-1:0] = s_r.los_cfg;
      else if (paddr == framer_status_0_addr)
        s_nxt.rdata[2:0] = {s_r.yellow, s_r.signal_loss_status, s_r.blue};
      else if (paddr == framer_status_1_addr)
        s_nxt.rdata[3:0] = {s_r.tx_zero, s_r.tx_short, s_r.density_violation,
                            s_r.exz};
      else if (paddr == irq_status_0_addr)
        s_nxt.rdata[0] = s_r.irq_status_0;
      else if (paddr == irq_status_1_addr)
        s_nxt.rdata[0] = s_r.irq_status_1;
      else if (paddr == irq_status_2_addr)
        s_nxt.rdata[3:0] = s_r.irq_status_2;
      else
        s_nxt.slverr = 1'b1;
      // a write answers with zero data, never the old register value
      if (pwrite)
        s_nxt.rdata = 32'h00000000;
    end
    if (apb_done && pwrite)
    begin
      if (paddr == ctrl_addr)
        s_nxt.ctrl = pwdata[ctrl_width-1:0];
      else if (paddr == los_cfg_addr)
        s_nxt.los_cfg = pwdata[los_cfg_width-1:0];
    end
    // read-to-clear drops only bits that were returned; a new event in
    // the same cycle sets again, so nothing is lost
    if (apb_done && !pwrite)
    begin
      if (paddr == framer_status_1_addr)
      begin
        if (s_r.rdata[zero_excess_bit] && !(rx_valid && exz_now))
          s_nxt.exz = 1'b0;
        if (s_r.rdata[density_bit] && !(rx_valid && pdv_now))
          s_nxt.density_violation = 1'b0;
      end
      else if (paddr == irq_status_0_addr)
      begin
        if (s_r.rdata[0] && !(rx_valid && pdv_now))
          s_nxt.irq_status_0 = 1'b0;
      end
      else if (paddr == irq_status_1_addr)
      begin
        if (s_r.rdata[0] && !(short_new != s_r.tx_short ||
            tzero_new != s_r.tx_zero))
          s_nxt.irq_status_1 = 1'b0;
      end
      else if (paddr == irq_status_2_addr)
        s_nxt.irq_status_2 = (s_r.irq_status_2 & ~s_r.rdata[3:0]) | irq_status_2_ev;
    end

    s_nxt.blue = blue_new;
    s_nxt.signal_loss_status = los_new;
    s_nxt.yellow = yellow_new;
    s_nxt.tx_short = short_new;
    s_nxt.tx_zero = tzero_new;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.ctrl <= ctrl_reset;
      s_r.los_cfg <= los_cfg_reset;
      s_r.age <= '1;
      s_r.fr_allz <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.slverr;
  assign tx_blue_alarm = s_r.ctrl[send_blue_alarm_bit];
  assign tx_yellow_alarm = s_r.ctrl[send_yellow_alarm_bit];

endmodule : t1_receive_alarm_monitor

// File: inc/alarm_pkg.sv
// constants for the t1 receive alarm monitor: register map, field
// positions, reset values and alarm thresholds.
// assumes one 32-bit apb slave with word-aligned registers.
package alarm_pkg;
  // register byte addresses
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] los_cfg_addr = 8'h04;
  localparam logic [7:0] framer_status_0_addr = 8'h08;
  localparam logic [7:0] framer_status_1_addr = 8'h0c;
  localparam logic [7:0] irq_status_0_addr = 8'h10;
  localparam logic [7:0] irq_status_1_addr = 8'h14;
  localparam logic [7:0] irq_status_2_addr = 8'h18;
  // control register fields
  localparam int send_blue_alarm_bit = 0;
  localparam int send_yellow_alarm_bit = 1;
  localparam int blue_threshold_sel_bit = 2;
  localparam int yellow_detect_sel_bit = 3;
  localparam int esf_mode_bit = 4;
  localparam int b8zs_mode_bit = 5;
  localparam int ctrl_width = 6;
  localparam logic [5:0] ctrl_reset = 6'h00;
  // loss-of-signal config: interval-1, ones-1, density recovery enable
  localparam int los_int_lsb = 0;
  localparam int los_ones_lsb = 12;
  localparam int los_dens_bit = 20;
  localparam int los_cfg_width = 21;
  localparam logic [20:0] los_cfg_reset = 21'h0000ff;
  localparam logic [11:0] los_int_min_m1 = 12'h00f;
  // framer_status_0 / framer_status_1 / irq_status_2 fields
  localparam int blue_bit = 0;
  localparam int los_bit = 1;
  localparam int yellow_bit = 2;
  localparam int yellow_rel_bit = 3;
  localparam int zero_excess_bit = 0;
  localparam int density_bit = 1;
  localparam int tx_short_bit = 2;
  localparam int tx_zero_run_bit = 3;
  // thresholds in received or transmitted pulse periods, slots, frames
  localparam logic [12:0] exz_b8zs_max = 13'd7;
  localparam logic [12:0] exz_ami_max = 13'd15;
  localparam logic [12:0] zero_run_max = 13'd15;
  localparam int density_n_max = 23;
  localparam logic [4:0] frames_d4 = 5'd12;
  localparam logic [4:0] frames_esf = 5'd24;
  localparam logic [7:0] blue_set_0 = 8'd3;
  localparam logic [7:0] blue_set_1_d4 = 8'd4;
  localparam logic [7:0] blue_set_1_esf = 8'd6;
  localparam logic [7:0] blue_clr_0 = 8'd2;
  localparam logic [7:0] blue_clr_1_d4 = 8'd3;
  localparam logic [7:0] blue_clr_1_esf = 8'd5;
  localparam logic [7:0] yellow_slots = 8'd255;
  localparam logic [1:0] yellow_rel_count = 2'd3;
  localparam logic [15:0] dl_yellow_pattern = 16'hff00;
  localparam logic [5:0] dl_len = 6'd16;
  localparam logic [1:0] tx_short_periods = 2'd3;
  localparam logic [5:0] tx_zero_limit = 6'd32;
endpackage : alarm_pkg

// File: tb/t1_line_source.sv
// model of the distant t1 terminal: received bit stream and line current.
// assumes one strobe per pulse period on pclk, frame of 193 bits.
`timescale 1ns/100ps
module t1_line_source
(
  input wire logic pclk,
  output logic rx_valid,
  output logic rx_bit,
  output logic rx_frame_start,
  output logic rx_slot_start,
  output logic rx_fs12,
  output logic rx_dl,
  output logic tx_current_high
);
  int pos = 0;
  initial
  begin
    rx_valid = 0;
    rx_bit = 0;
    rx_frame_start = 0;
    rx_slot_start = 0;
    rx_fs12 = 0;
    rx_dl = 0;
    tx_current_high = 0;
  end
  // between strobes the bit line flips so a stale value is never reused
  task automatic send(input int n, input logic v, input int gap);
    repeat (n)
    begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_bit <= v;
      rx_frame_start <= (pos == 0);
      rx_slot_start <= (pos % 8 == 1);
      pos = (pos + 1) % 193;
      repeat (gap)
      begin
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_bit <= ~v;
        rx_frame_start <= 1'b0;
        rx_slot_start <= 1'b0;
      end
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_bit <= ~v;
    rx_frame_start <= 1'b0;
    rx_slot_start <= 1'b0;
  endtask : send
  task automatic set_current(input logic v);
    @(posedge pclk);
    tx_current_high <= v;
  endtask : set_current
endmodule : t1_line_source

// File: tb/t1_receive_alarm_monitor_assertions.sv
// port-level checks for the t1 receive alarm monitor.
// assumes an apb master that holds each request until pready.
`timescale 1ns/100ps
module t1_receive_alarm_monitor_checker
  import alarm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_blue_alarm,
  input wire logic tx_yellow_alarm
);
  logic mapped;
  logic ctrl_wr;
  assign mapped = (paddr <= irq_status_2_addr) && (paddr[1:0] == 2'b00);
  assign ctrl_wr = psel && pwrite && (paddr == ctrl_addr);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_blue_send_value: assert property (
    ctrl_wr && penable && pready |->
    ##2 tx_blue_alarm == $past(pwdata[send_blue_alarm_bit], 2))
    else $error("blue send output differs from written control");
  chk_blue_send_cause: assert property (
    $changed(tx_blue_alarm) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("blue send output moved without a control write");
  chk_yellow_send_value: assert property (
    ctrl_wr && penable && pready |->
    ##2 tx_yellow_alarm == $past(pwdata[send_yellow_alarm_bit], 2))
    else $error("yellow send output differs from written control");
  chk_yellow_send_cause: assert property (
    $changed(tx_yellow_alarm) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("yellow send output moved without a control write");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_pready_wait: assert property ($rose(penable) && psel |->
    !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  chk_write_rdata: assert property (pready && (pwrite || !mapped) |->
    prdata == 32'h0)
    else $error("read data not zero on write or unmapped access");
  chk_status_unused: assert property (pready && !pwrite &&
    paddr == framer_status_0_addr |-> prdata[31:3] == 29'h0)
    else $error("unused status bits not zero");
endmodule : t1_receive_alarm_monitor_checker

bind t1_receive_alarm_monitor t1_receive_alarm_monitor_checker
  t1_receive_alarm_monitor_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_blue_alarm(tx_blue_alarm), .tx_yellow_alarm(tx_yellow_alarm));

// File: tb/tb_t1_receive_alarm_monitor.sv
// self-checking bench: apb reads queue their expected value, a monitor
// compares each read answer. assumes the line model drives the rx side.
`timescale 1ns/100ps
`define check_eq(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_t1_receive_alarm_monitor;
  import alarm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, exp_v;
  logic rx_valid, rx_bit, rx_frame_start, rx_slot_start, rx_fs12, rx_dl;
  logic tx_valid, tx_bit, tx_current_high, tx_blue_alarm, tx_yellow_alarm;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h53df;
  t1_receive_alarm_monitor t1_receive_alarm_monitor_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .rx_frame_start(rx_frame_start), .rx_slot_start(rx_slot_start),
    .rx_fs12(rx_fs12), .rx_dl(rx_dl), .tx_valid(tx_valid), .tx_bit(tx_bit),
    .tx_current_high(tx_current_high), .tx_blue_alarm(tx_blue_alarm),
    .tx_yellow_alarm(tx_yellow_alarm));
  t1_line_source t1_line_source_inst (.pclk(pclk), .rx_valid(rx_valid),
    .rx_bit(rx_bit), .rx_frame_start(rx_frame_start),
    .rx_slot_start(rx_slot_start), .rx_fs12(rx_fs12), .rx_dl(rx_dl),
    .tx_current_high(tx_current_high));
  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait assumed; only the watchdog ends a hung slave
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // random spacing between received bits, up to two idle cycles
  task automatic rx(input int n, input logic v);
    t1_line_source_inst.send(n, v, $unsigned($random(seed)) % 3);
  endtask : rx
  task automatic tx(input int n, input logic v);
    repeat (n)
    begin
      @(posedge pclk);
      tx_valid <= 1'b1;
      tx_bit <= v;
    end
    @(posedge pclk);
    tx_valid <= 1'b0;
  endtask : tx
  task finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      exp_v = exp_q.pop_front();
      `check_eq(prdata, exp_v)
    end
  initial
  begin
    #400000;
    fail_count++;
    finish_test;
  end
  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    tx_valid = 0;
    tx_bit = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ctrl_addr, 32'h0);
    rd(los_cfg_addr, 32'h0000_00ff);
    rd(framer_status_1_addr, 32'h0);
    rd(8'h1c, 32'h0);
    apb(1'b1, 8'h20, $random(seed));
    rd(ctrl_addr, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, ctrl_addr, i);
      repeat (2) @(posedge pclk);
      #1;
      `check_eq(tx_blue_alarm, i[0])
      `check_eq(tx_yellow_alarm, i[1])
      rd(ctrl_addr, i);
    end
    apb(1'b1, ctrl_addr, 32'h0);
    // shortest loss interval, one one needed to recover
    apb(1'b1, los_cfg_addr, 32'h0000_000f);
    rd(los_cfg_addr, 32'h0000_000f);
    rx(15, 1'b0);
    rd(framer_status_0_addr, 32'h0);
    rd(framer_status_1_addr, 32'h0);
    rx(1, 1'b0);
    rd(framer_status_0_addr, 32'h2);
    rd(irq_status_2_addr, 32'h2);
    rd(framer_status_1_addr, 32'h3);
    rd(irq_status_0_addr, 32'h1);
    rd(framer_status_1_addr, 32'h0);
    rd(irq_status_0_addr, 32'h0);
    rd(irq_status_2_addr, 32'h0);
    rx(32, 1'b1);
    rd(framer_status_0_addr, 32'h0);
    rd(irq_status_2_addr, 32'h2);
    // b8zs lowers the zero limit to 7
    apb(1'b1, ctrl_addr, 32'h20);
    rx(7, 1'b0);
    rd(framer_status_1_addr, 32'h0);
    rx(1, 1'b0);
    rd(framer_status_1_addr, 32'h1);
    rd(framer_status_1_addr, 32'h0);
    t1_line_source_inst.set_current(1'b1);
    repeat (3) @(posedge pclk);
    tx(3, 1'b1);
    rd(framer_status_1_addr, 32'h0);
    tx(1, 1'b1);
    rd(framer_status_1_addr, 32'h4);
    rd(irq_status_1_addr, 32'h1);
    t1_line_source_inst.set_current(1'b0);
    repeat (4) @(posedge pclk);
    rd(framer_status_1_addr, 32'h0);
    rd(irq_status_1_addr, 32'h1);
    rd(irq_status_1_addr, 32'h0);
    tx(31, 1'b0);
    rd(framer_status_1_addr, 32'h0);
    tx(1, 1'b0);
    rd(framer_status_1_addr, 32'h8);
    rd(irq_status_1_addr, 32'h1);
    tx(1, 1'b1);
    rd(framer_status_1_addr, 32'h0);
    rd(irq_status_1_addr, 32'h1);
    // all-ones multiframe raises blue; three zeros in the next clear it
    t1_line_source_inst.send(4383, 1'b1, 0);
    rd(framer_status_0_addr, 32'h0);
    t1_line_source_inst.send(1, 1'b1, 0);
    rd(framer_status_0_addr, 32'h1);
    rd(irq_status_2_addr, 32'h1);
    t1_line_source_inst.send(3, 1'b0, 0);
    t1_line_source_inst.send(2313, 1'b1, 0);
    rd(framer_status_0_addr, 32'h0);
    rd(irq_status_2_addr, 32'h1);
    // selector 1: one frame with every bit 2 zero, then three clean frames
    apb(1'b1, ctrl_addr, 32'h28);
    for (int k = 0; k < 24; k++)
    begin
      t1_line_source_inst.send(1, 1'b1, 0);
      t1_line_source_inst.send(1, 1'b0, 0);
      t1_line_source_inst.send(6, 1'b1, 0);
    end
    t1_line_source_inst.send(1, 1'b1, 0);
    rd(framer_status_0_addr, 32'h4);
    rd(irq_status_2_addr, 32'h4);
    t1_line_source_inst.send(579, 1'b1, 0);
    rd(framer_status_0_addr, 32'h0);
    rd(irq_status_2_addr, 32'h8);
    repeat (3) @(posedge pclk);
    finish_test;
  end
endmodule : tb_t1_receive_alarm_monitor
